// ===== bench/epv_core_model.sv
// Core-side partner: returns from the active handler on request.
// Assumes the bench pulses ret_req and sets the return lag.
`timescale 1ns/1ps
`default_nettype none
module epv_core_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        take_valid,
  input  wire logic [31:0] take_addr,
  input  wire logic        ret_req,
  input  wire logic [3:0]  lag,
  output logic             act_done,
  output logic [31:0]      handler_word
);
  // ------------------------------------------------------------------
  // Handler return
  // ------------------------------------------------------------------
  // A lag lets a handler run long, so later arrivals meet it active
  logic [4:0] wait_reg;
  always_ff @(posedge clk)
  begin
    act_done <= 1'b0;
    if (rst)
      wait_reg <= 5'h00;
    else if (ret_req)
      wait_reg <= {1'b0, lag} + 5'h01;
    else if (wait_reg != 5'h00)
    begin
      wait_reg <= wait_reg - 5'h01;
      act_done <= (wait_reg == 5'h01);
    end
  end
  // Fetched handler word always marks compact code
  always_ff @(posedge clk)
    if (take_valid)
      handler_word <= {take_addr[31:1], 1'b1};
endmodule
`default_nettype wire

// ===== bench/epv_exception_priority_vector_tb.sv
// Self-checking bench for the exception priority and vector block.
// Assumes the core model returns handlers when asked.
`timescale 1ns/1ps
`default_nettype none
module epv_exception_priority_vector_tb;
  // ------------------------------------------------------------------
  // Stimulus and wiring
  // ------------------------------------------------------------------
  logic clk, rst, pri_we, base_we, base_priv, act_done, ret_req;
  logic take_valid, active;
  logic [59:0] exc_req, pend;
  logic [5:0] pri_vec, take_vec, act_vec;
  logic [2:0] pri_val;
  logic [3:0] lag;
  logic [31:0] base_val, take_addr, vec_base, hword;
  int fail_count, compares;
  logic [31:0] bv [6] = '{32'h100, 32'h200, 32'h280, 32'h4000_0000,
                          32'h3fff_ff00, 32'h80};
  logic bp [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [31:0] be [6] = '{32'h100, 32'h100, 32'h100, 32'h100,
                          32'h3fff_ff00, 32'h3fff_ff00};

  epv_exception_priority_vector epv_exception_priority_vector_i
  (.CLK_SYS(clk), .RESET(rst), .EXC_REQ(exc_req), .PRI_WE(pri_we),
   .PRI_VEC(pri_vec), .PRI_VAL(pri_val), .BASE_WE(base_we),
   .BASE_PRIV(base_priv), .BASE_VAL(base_val), .ACT_DONE(act_done),
   .TAKE_VALID(take_valid), .TAKE_VEC(take_vec), .TAKE_ADDR(take_addr),
   .VEC_BASE(vec_base), .PEND(pend), .ACT_VEC(act_vec), .ACTIVE(active));

  epv_core_model epv_core_model_i
  (.clk(clk), .rst(rst), .take_valid(take_valid), .take_addr(take_addr),
   .ret_req(ret_req), .lag(lag), .act_done(act_done), .handler_word(hword));

  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [59:0] seen,
                       input logic [59:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic raise(input logic [59:0] v);
    @(posedge clk);
    exc_req <= v;
    @(posedge clk);
    exc_req <= '0;
  endtask

  task automatic ret(input logic [3:0] l);
    @(posedge clk);
    lag <= l;
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
  endtask

  task automatic setpri(input logic [5:0] v, input logic [2:0] p);
    @(posedge clk);
    pri_we <= 1'b1;
    pri_vec <= v;
    pri_val <= p;
    @(posedge clk);
    pri_we <= 1'b0;
  endtask

  task automatic wait_take(input logic [5:0] v, input logic [31:0] a);
    int n;
    for (n = 0; n < 30; n++)
    begin
      tick(1);
      if (take_valid === 1'b1)
        break;
    end
    if (take_valid !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
    check("take_vec", take_vec, v);
    check("take_addr", take_addr, a);
    tick(1);
    check("handler_word", hword, {a[31:1], 1'b1});
  endtask

  task automatic no_take(input int n);
    int hits;
    hits = 0;
    repeat (n)
    begin
      tick(1);
      hits += (take_valid === 1'b1);
    end
    check("no_take", hits, 0);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic s_tie();
    raise(60'h3 << 16);
    wait_take(6'd16, 32'h40);
    no_take(8);
    check("pend17", pend[17], 1'b1);
    ret(4'h3);
    wait_take(6'd17, 32'h44);
    ret(4'h0);
    tick(6);
  endtask

  task automatic s_prio();
    setpri(6'd16, 3'h5);
    setpri(6'd17, 3'h2);
    setpri(6'd2, 3'h7);
    raise(60'h3 << 16);
    wait_take(6'd17, 32'h44);
    raise(60'h1 << 18);
    wait_take(6'd18, 32'h48);
    raise(60'h1 << 2);
    wait_take(6'd2, 32'h08);
    ret(4'h0);
    no_take(6);
    ret(4'h0);
    no_take(6);
    ret(4'h0);
    wait_take(6'd16, 32'h40);
    ret(4'h0);
    tick(6);
  endtask

  task automatic s_base();
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      base_we <= 1'b1;
      base_val <= bv[i];
      base_priv <= bp[i];
      @(posedge clk);
      base_we <= 1'b0;
      tick(2);
      check("vec_base", vec_base, be[i]);
    end
    raise(60'h1 << 16);
    wait_take(6'd16, 32'h3fff_ff40);
    ret(4'h0);
    tick(6);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    {rst, pri_we, base_we, base_priv, ret_req} = 5'h10;
    {exc_req, pri_vec, pri_val, lag, base_val} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    check("vec_base", vec_base, 32'h0);
    check("active", active, 1'b0);
    raise(60'h1 << 16);
    wait_take(6'd16, 32'h40);
    ret(4'h0);
    tick(6);
    check("active", active, 1'b0);
    s_tie();
    raise((60'h1 << 25) | (60'h1 << 54));
    no_take(8);
    check("pend", pend, 60'h0);
    s_prio();
    s_base();
    close_out();
  end
endmodule
`default_nettype wire

// ===== rtl/epv_exception_priority_vector.sv
// Exception prioritisation and vector address generation.
// Assumes the core pulses ACT_DONE when the active handler returns and
// that all inputs are synchronous to CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
module epv_exception_priority_vector
(
  input  wire logic                      CLK_SYS,
  input  wire logic                      RESET,
  input  wire logic [epv_pkg::NUM_VEC-1:0] EXC_REQ,
  input  wire logic                      PRI_WE,
  input  wire logic [epv_pkg::VEC_W-1:0] PRI_VEC,
  input  wire logic [2:0]                PRI_VAL,
  input  wire logic                      BASE_WE,
  input  wire logic                      BASE_PRIV,
  input  wire logic [31:0]               BASE_VAL,
  input  wire logic                      ACT_DONE,
  output logic                           TAKE_VALID,
  output logic [epv_pkg::VEC_W-1:0]      TAKE_VEC,
  output logic [31:0]                    TAKE_ADDR,
  output logic [31:0]                    VEC_BASE,
  output logic [epv_pkg::NUM_VEC-1:0]    PEND,
  output logic [epv_pkg::VEC_W-1:0]      ACT_VEC,
  output logic                           ACTIVE
);

  // --------------------------------------------------------------------
  // Priority store
  // --------------------------------------------------------------------
  logic [2:0] pri_reg [epv_pkg::NUM_VEC];
  logic [31:0] base_reg;
  logic [epv_pkg::NUM_VEC-1:0] pend_reg;
  epv_pkg::epv_vec_t act_reg;
  epv_pkg::epv_pri_t act_pri_reg;
  logic [3:0] depth_reg;
  epv_pkg::epv_pri_t stk_pri [16];
  epv_pkg::epv_vec_t stk_vec [16];

  genvar gi;
  generate
    for (gi = 0; gi < epv_pkg::NUM_VEC; gi++)
    begin : g_pri
      always_ff @(posedge CLK_SYS)
      begin
        if (RESET)
          pri_reg[gi] <= epv_pkg::PRI_RST_VAL;
        else if (PRI_WE && PRI_VEC == epv_pkg::epv_vec_t'(gi)
                 && epv_pkg::VEC_PROG_MASK[gi])
          pri_reg[gi] <= PRI_VAL & epv_pkg::PRI_MAX;
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Table base
  // --------------------------------------------------------------------
  // Out-of-range or unaligned writes are dropped rather than truncated
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      base_reg <= epv_pkg::BASE_RST;
    else if (BASE_WE && BASE_PRIV && BASE_VAL >= epv_pkg::BASE_MIN
             && BASE_VAL <= epv_pkg::BASE_MAX
             && (BASE_VAL & epv_pkg::BASE_ALIGN) == 32'h0)
      base_reg <= BASE_VAL;
  end

  // --------------------------------------------------------------------
  // Selection
  // --------------------------------------------------------------------
  function automatic epv_pkg::epv_pri_t eff_pri(input int v,
                                                input logic [2:0] p);
    epv_pkg::epv_pri_t r;
    r = epv_pkg::epv_pri_t'({1'b0, p});
    if (v == 1)
      r = epv_pkg::PRI_RESET;
    else if (v == 2)
      r = epv_pkg::PRI_NMI;
    else if (v == 3)
      r = epv_pkg::PRI_HARD;
    return r;
  endfunction

  epv_pkg::epv_vec_t best_vec;
  epv_pkg::epv_pri_t best_pri;
  logic              best_any;
  logic [epv_pkg::NUM_VEC-1:0] live;

  // Vector zero and unsourced reserved slots never become pending
  localparam logic [epv_pkg::NUM_VEC-1:0] SRC_MASK =
    epv_pkg::VEC_PROG_MASK | 60'h0e;
  assign live = pend_reg & SRC_MASK;

  always_comb
  begin
    best_vec = '0;
    best_pri = epv_pkg::PRI_IDLE;
    best_any = 1'b0;
    // Strict less-than keeps the lowest number on a tie
    for (int v = 0; v < epv_pkg::NUM_VEC; v++)
    begin
      if (live[v] && (!best_any || eff_pri(v, pri_reg[v]) < best_pri))
      begin
        best_any = 1'b1;
        best_pri = eff_pri(v, pri_reg[v]);
        best_vec = epv_pkg::epv_vec_t'(v);
      end
    end
  end

  logic take;
  assign take = best_any && !TAKE_VALID &&
                (depth_reg == 4'h0 || best_pri < act_pri_reg);

  // --------------------------------------------------------------------
  // Pending
  // --------------------------------------------------------------------
  // A new request wins over the clear of the same cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      pend_reg <= '0;
    else
    begin
      for (int v = 0; v < epv_pkg::NUM_VEC; v++)
        if (EXC_REQ[v] && SRC_MASK[v])
          pend_reg[v] <= 1'b1;
        else if (take && best_vec == epv_pkg::epv_vec_t'(v))
          pend_reg[v] <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Active stack
  // --------------------------------------------------------------------
  // Eight programmable levels and three fixed ones nest at most eleven
  // deep, as preemption needs a strictly more urgent value; sixteen
  // entries keep the index in range without a guard.
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      depth_reg   <= 4'h0;
      act_reg     <= '0;
      act_pri_reg <= epv_pkg::PRI_IDLE;
    end
    else if (take && ACT_DONE && depth_reg != 4'h0)
    begin
      // Return and entry together: the new handler takes the top level
      // so the returning one is not left stranded on the stack
      act_reg     <= best_vec;
      act_pri_reg <= best_pri;
    end
    else if (take)
    begin
      stk_pri[depth_reg] <= act_pri_reg;
      stk_vec[depth_reg] <= act_reg;
      depth_reg   <= depth_reg + 4'h1;
      act_reg     <= best_vec;
      act_pri_reg <= best_pri;
    end
    else if (ACT_DONE && depth_reg != 4'h0)
    begin
      depth_reg   <= depth_reg - 4'h1;
      act_reg     <= stk_vec[depth_reg - 4'h1];
      act_pri_reg <= stk_pri[depth_reg - 4'h1];
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      TAKE_VALID <= 1'b0;
      TAKE_VEC   <= '0;
      TAKE_ADDR  <= epv_pkg::BASE_RST;
    end
    else
    begin
      TAKE_VALID <= take;
      if (take)
      begin
        TAKE_VEC  <= best_vec;
        TAKE_ADDR <= base_reg + {24'h0, best_vec, 2'b00};
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      VEC_BASE <= epv_pkg::BASE_RST;
      PEND     <= '0;
      ACT_VEC  <= '0;
      ACTIVE   <= 1'b0;
    end
    else
    begin
      VEC_BASE <= base_reg;
      PEND     <= pend_reg;
      ACT_VEC  <= act_reg;
      ACTIVE   <= depth_reg != 4'h0;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_take;
    take;
  endsequence

  // A take that adds a level, and a return that removes one
  sequence s_push;
    take && !(ACT_DONE && depth_reg != 4'h0);
  endsequence

  sequence s_pop;
    ACT_DONE && !take && depth_reg != 4'h0;
  endsequence

  a_base_reset: assert property (
    @(posedge CLK_SYS) $past(RESET) |-> base_reg == 32'h0)
    else $error("base not zero after reset");
  a_pri_reset: assert property (
    @(posedge CLK_SYS) $past(RESET) |-> pri_reg[16] == 3'h0)
    else $error("priority not zero after reset");
  a_fetch_addr: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    s_take |=> TAKE_VALID && TAKE_ADDR == $past(base_reg)
      + 32'($past(best_vec)) * 4)
    else $error("vector fetch address wrong");
  a_irq_offset: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (s_take and best_vec >= 6'd16 and base_reg == 32'h0) |=>
      TAKE_ADDR == 32'h40 + 32'(TAKE_VEC - 6'd16) * 4)
    else $error("interrupt offset wrong");
  a_base_range: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    base_reg == 32'h0 || (base_reg >= 32'h100 && base_reg <= 32'h3fffff00
      && base_reg[7:0] == 8'h0))
    else $error("base out of range");
  a_pri_range: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    best_any |-> best_pri <= 4'sh7)
    else $error("priority above seven");
  a_no_equal: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (depth_reg != 4'h0 && best_any && best_pri >= act_pri_reg) |-> !take)
    else $error("equal priority preempted");
  a_preempt: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (best_any && !TAKE_VALID && best_pri < act_pri_reg) |-> ##1 TAKE_VALID)
    else $error("urgent exception not taken");
  a_fixed_win: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (s_take and live[2]) |-> best_vec <= 6'd2)
    else $error("fixed priority lost");
  a_tie_low: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (s_take and live[16] and live[17] and pri_reg[16] == pri_reg[17])
      |-> best_vec != 6'd17)
    else $error("tie broken wrong");
  a_take_pulse: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    TAKE_VALID |=> !TAKE_VALID)
    else $error("take held for two cycles");
  a_sp_word: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    s_take |-> best_vec != 6'h00)
    else $error("stack pointer word taken as vector");
  a_pend_rsvd: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (pend_reg & ~SRC_MASK) == '0)
    else $error("reserved slot pending");
  a_pri_write: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (PRI_WE && PRI_VEC == 6'd17) |=> pri_reg[17] == $past(PRI_VAL))
    else $error("priority write lost");
  a_fixed_keep: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    pri_reg[2] == epv_pkg::PRI_RST_VAL)
    else $error("fixed priority store written");
  a_base_hold: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (BASE_WE && !BASE_PRIV) |=> $stable(base_reg))
    else $error("unprivileged base write taken");
  a_base_write: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (BASE_WE && BASE_PRIV && BASE_VAL == 32'h100) |=> base_reg == 32'h100)
    else $error("privileged base write lost");
  a_take_push: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    s_push |=> depth_reg == $past(depth_reg) + 4'h1)
    else $error("take did not nest");
  a_pop_level: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    s_pop |=> depth_reg == $past(depth_reg) - 4'h1
      && act_pri_reg >= $past(act_pri_reg))
    else $error("return did not restore level");
  a_depth_cap: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    depth_reg <= 4'd11)
    else $error("nesting deeper than levels allow");
  a_idle_take: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (depth_reg == 4'h0 && best_any && !TAKE_VALID) |=>
      TAKE_VALID && TAKE_VEC == $past(best_vec))
    else $error("idle block did not take best");
  a_act_flag: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    ACTIVE == ($past(depth_reg) != 4'h0))
    else $error("active flag wrong");

endmodule
`default_nettype wire

// ===== rtl/epv_pkg.sv
// Constants, types and field layouts for the exception priority and vector
// logic. Assumes a single 20 MHz system clock and synchronous reset.
// Behaviour
// - Programmable priorities reset to zero
// - IRQ n is vector n+16, offset 0x40+4n
// - Table word zero holds initial stack pointer
// - Table base is zero after reset
// - Privileged write relocates base within range
// - Smaller value wins; three fixed priorities
// - Programmable fields accept only 0 to 7
// - Equal priority: lowest exception number first
// - More urgent arrival preempts active handler
// - Equal priority never preempts; stays pending
package epv_pkg;

  // --------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------
  localparam int NUM_IRQ     = 44;
  localparam int NUM_VEC     = 60;
  localparam int VEC_W       = 6;
  localparam int PRI_W       = 4;
  localparam int IRQ_VEC_OFS = 16;

  typedef logic [VEC_W-1:0] epv_vec_t;
  typedef logic signed [PRI_W-1:0] epv_pri_t;

  // --------------------------------------------------------------------
  // Fixed vectors and priorities
  // --------------------------------------------------------------------
  localparam epv_vec_t VEC_RESET = 6'h01;
  localparam epv_vec_t VEC_NMI   = 6'h02;
  localparam epv_vec_t VEC_HARD  = 6'h03;
  localparam epv_pri_t PRI_RESET = -4'sd3;
  localparam epv_pri_t PRI_NMI   = -4'sd2;
  localparam epv_pri_t PRI_HARD  = -4'sd1;
  localparam epv_pri_t PRI_IDLE  = 4'sh7 + 4'sh0;
  localparam logic [2:0] PRI_RST_VAL = 3'h0;
  localparam logic [2:0] PRI_MAX     = 3'h7;

  // Vectors with programmable priority and a real source
  localparam logic [NUM_VEC-1:0] VEC_PROG_MASK =
    60'h83f_ffff_e1ff_d870;

  // --------------------------------------------------------------------
  // Table base
  // --------------------------------------------------------------------
  localparam logic [31:0] BASE_RST   = 32'h0000_0000;
  localparam logic [31:0] BASE_MIN   = 32'h0000_0100;
  localparam logic [31:0] BASE_MAX   = 32'h3fff_ff00;
  localparam logic [31:0] BASE_ALIGN = 32'h0000_00ff;
  localparam int          SP_WORD    = 0;

  typedef struct packed {
    logic        valid;
    epv_vec_t    vec;
    logic [31:0] addr;
  } epv_take_s;

  typedef enum logic [1:0] {EPV_THREAD, EPV_HANDLER} epv_mode_e;

endpackage
